// ==== src/rtdf_pkg.sv ====
/*
 * Shared constants and types for the resistance result and fault block.
 * Assumes one clock (mclk) and the serial register port of the device.
 */
//==============================================================
// Behaviour
// [R1] result_pending_n goes low when a new result is in the result registers.
// [R2] result_pending_n returns high once a host read of the result bytes ends.
// [R3] a result that arrives before the last was read overwrites it, pin low.
// [R4] the 15-bit code is held across the result bytes at offsets 01h and 02h.
// [R5] the host gets resistance as code times reference resistance over 2^15.
// [R6] open and shorted element checks run on every conversion result.
// [R7] an open sensing element yields a full-scale code.
// [R8] a shorted sensing element yields a code near zero.
// [R9] a result at or above the high trip threshold sets over_range_flag.
// [R10] the host sets the low trip threshold to catch a shorted element.
// [R11] a result at or below the low trip threshold sets under_range_flag.
// [R12] on request, reference_input_neg above 0.85 of bias sets a fault bit.
// [R13] fault bits stay latched until the fault-clear bit is set.
// [R14] writing one to the fault-clear bit returns all fault bits to zero.
// [R15] the host waits five filter time constants plus 1 ms before restart.
// [R16] at power-on high threshold is FFFFh and low threshold 0000h.
package rtdf_pkg;

    //==========================================================
    // register offsets (address bits 6:0)
    localparam logic [6:0] ADR_CFG    = 7'h00;
    localparam logic [6:0] ADR_RES_HI = 7'h01;
    localparam logic [6:0] ADR_RES_LO = 7'h02;
    localparam logic [6:0] ADR_HTH_HI = 7'h03;
    localparam logic [6:0] ADR_HTH_LO = 7'h04;
    localparam logic [6:0] ADR_LTH_HI = 7'h05;
    localparam logic [6:0] ADR_LTH_LO = 7'h06;
    localparam logic [6:0] ADR_FLT    = 7'h07;

    //==========================================================
    // field positions
    localparam int unsigned CFG_CLR_BIT   = 1;
    localparam int unsigned CFG_DET_BIT   = 2;
    localparam int unsigned FLT_OVER_BIT  = 7;
    localparam int unsigned FLT_UNDER_BIT = 6;
    localparam int unsigned FLT_REF_BIT   = 5;
    localparam int unsigned ADR_WR_BIT    = 7;
    localparam logic [7:0]  CFG_SELF_MASK = 8'h06;

    //==========================================================
    // reset and fixed values
    localparam logic [7:0]  CFG_RST    = 8'h00;
    localparam logic [7:0]  FLT_RST    = 8'h00;
    localparam logic [15:0] HTH_RST    = 16'hffff;
    localparam logic [15:0] LTH_RST    = 16'h0000;
    localparam logic [14:0] RES_RST    = 15'h0000;
    localparam logic [7:0]  INVALID_RD = 8'hff;
    localparam logic [14:0] CODE_FULL  = 15'h7fff;
    localparam logic [14:0] CODE_ZERO  = 15'h0000;
    localparam logic [5:0]  PIN_RST    = 6'h20;

    //==========================================================
    // carriers
    typedef struct packed {
        logic        done;
        logic [14:0] code;
    } rtdf_conv_t;

    typedef struct packed {
        logic over;
        logic under;
    } rtdf_trip_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ADDR = 2'b01,
        PH_DATA = 2'b10
    } rtdf_phase_t;

endpackage : rtdf_pkg

// ==== src/rtdf_sync.sv ====
/*
 * Two-flop synchroniser for a bundle of asynchronous levels.
 * Assumes each bit is a slow level; no bus coherence is promised.
 */
`timescale 1ns/1ps
`default_nettype none
module rtdf_sync #(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         mclk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s1_ff <= RST;
            s2_ff <= RST;
        end else begin
            s1_ff <= d;
            s2_ff <= s1_ff;
        end
    end

    assign q = s2_ff;
endmodule : rtdf_sync
`default_nettype wire

// ==== src/rtdf_trip.sv ====
/*
 * Conditions a finished conversion code and compares it with the trip
 * thresholds. Assumes the threshold format of the result (bit 0 unused).
 */
`timescale 1ns/1ps
`default_nettype none
module rtdf_trip import rtdf_pkg::*; (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire rtdf_conv_t  conv_raw,
    input  wire logic        elem_open,
    input  wire logic        elem_short,
    input  wire logic [15:0] high_thr,
    input  wire logic [15:0] low_thr,
    output rtdf_conv_t       conv_q,
    output rtdf_trip_t       trip_q
);
    rtdf_conv_t conv_ff;
    rtdf_conv_t nxt_conv;
    rtdf_trip_t trip_ff;
    rtdf_trip_t nxt_trip;

    always_comb begin
        nxt_conv.done = conv_raw.done;
        nxt_conv.code = conv_raw.code;
        // [R7] open element reads full scale
        if (elem_open) begin
            nxt_conv.code = CODE_FULL;
        // [R8] shorted element reads zero
        end else if (elem_short) begin
            nxt_conv.code = CODE_ZERO;
        end
        // [R6] checked on every result
        // [R9] at or above high threshold
        nxt_trip.over  = conv_raw.done && (nxt_conv.code >= high_thr[15:1]);
        // [R11] at or below low threshold
        nxt_trip.under = conv_raw.done && (nxt_conv.code <= low_thr[15:1]);
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            conv_ff <= '0;
            trip_ff <= '0;
        end else begin
            conv_ff <= nxt_conv;
            trip_ff <= nxt_trip;
        end
    end

    assign conv_q = conv_ff;
    assign trip_q = trip_ff;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_open_full: assert property ( // [R7]
        conv_raw.done && elem_open |=> conv_q.code == CODE_FULL && trip_q.over)
        else $error("open element did not give full scale");
    a_short_zero: assert property ( // [R8]
        conv_raw.done && elem_short && !elem_open
        |=> conv_q.code == CODE_ZERO && trip_q.under)
        else $error("short element did not give zero");
    a_under_trip: assert property ( // [R11]
        conv_raw.done && !elem_open && !elem_short
        && conv_raw.code <= low_thr[15:1] |=> trip_q.under)
        else $error("under range not tripped");
endmodule : rtdf_trip
`default_nettype wire

// ==== src/rtdf_core.sv ====
/*
 * Result publication, fault flagging and serial register port.
 * Assumes mclk far faster than the serial clock, CPHA=1 host, and the
 * conversion engine giving a one-cycle done strobe on mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module rtdf_core import rtdf_pkg::*; (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic       sdi,
    output logic            sdo_o,
    output logic            sdo_oe,
    output logic            result_pending_n,
    input  wire rtdf_conv_t conv_in,
    input  wire logic       element_open,
    input  wire logic       element_short,
    input  wire logic       reference_input_neg_high
);
    //==========================================================
    // pin synchronisers
    logic [5:0]  pins_s;
    logic        cs_s;
    logic        sclk_s;
    logic        sdi_s;
    logic        open_s;
    logic        short_s;
    logic        refhi_s;

    rtdf_sync #(
        .W   (6),
        .RST (PIN_RST)
    ) u_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .d       ({cs_n, sclk, sdi, element_open, element_short,
                   reference_input_neg_high}),
        .q       (pins_s)
    );

    assign {cs_s, sclk_s, sdi_s, open_s, short_s, refhi_s} = pins_s;

    //==========================================================
    // state
    rtdf_phase_t phase_ff;
    rtdf_phase_t nxt_phase;
    logic        idle_ff;
    logic        nxt_idle;
    logic        sclk_d_ff;
    logic        cs_d_ff;
    logic [2:0]  bcnt_ff;
    logic [2:0]  nxt_bcnt;
    logic [7:0]  sh_ff;
    logic [7:0]  nxt_sh;
    logic [7:0]  out_ff;
    logic [7:0]  nxt_out;
    logic [7:0]  addr_ff;
    logic [7:0]  nxt_addr;
    logic        sdo_ff;
    logic        nxt_sdo;
    logic        rdtouch_ff;
    logic        nxt_rdtouch;
    logic [7:0]  cfg_ff;
    logic [7:0]  nxt_cfg;
    logic [15:0] hth_ff;
    logic [15:0] nxt_hth;
    logic [15:0] lth_ff;
    logic [15:0] nxt_lth;
    logic [7:0]  flt_ff;
    logic [7:0]  nxt_flt;
    logic [14:0] res_ff;
    logic [14:0] nxt_res;
    logic        pend_n_ff;
    logic        nxt_pend_n;

    rtdf_conv_t  tconv;
    rtdf_trip_t  trip;

    //==========================================================
    // serial edge decode
    logic       active;
    logic       strobe;
    logic       shift_e;
    logic       byte_done;
    logic [7:0] byte_in;
    logic       cs_rise;
    logic       wr_en;
    logic [6:0] idx;
    logic       clr_p;
    logic       det_p;

    // idle level is caught at select, so either clock polarity works
    assign active    = !cs_s && !cs_d_ff && phase_ff != PH_IDLE;
    assign strobe    = active && sclk_s != sclk_d_ff && sclk_s == idle_ff;
    assign shift_e   = active && sclk_s != sclk_d_ff && sclk_s != idle_ff;
    assign byte_done = strobe && bcnt_ff == 3'h7;
    assign byte_in   = {sh_ff[6:0], sdi_s};
    assign cs_rise   = cs_s && !cs_d_ff;
    assign idx       = addr_ff[6:0];
    assign wr_en     = byte_done && phase_ff == PH_DATA
                       && addr_ff[ADR_WR_BIT];
    assign clr_p     = wr_en && idx == ADR_CFG && byte_in[CFG_CLR_BIT];
    assign det_p     = wr_en && idx == ADR_CFG && byte_in[CFG_DET_BIT];

    function automatic logic [7:0] reg_rd(input logic [6:0] a);
        case (a)
            ADR_CFG:    reg_rd = cfg_ff;
            // [R4] code split over two bytes
            ADR_RES_HI: reg_rd = res_ff[14:7];
            ADR_RES_LO: reg_rd = {res_ff[6:0], |flt_ff};
            ADR_HTH_HI: reg_rd = hth_ff[15:8];
            ADR_HTH_LO: reg_rd = hth_ff[7:0];
            ADR_LTH_HI: reg_rd = lth_ff[15:8];
            ADR_LTH_LO: reg_rd = lth_ff[7:0];
            ADR_FLT:    reg_rd = flt_ff;
            default:    reg_rd = INVALID_RD;
        endcase
    endfunction : reg_rd

    function automatic logic is_res(input logic [6:0] a);
        is_res = a == ADR_RES_HI || a == ADR_RES_LO;
    endfunction : is_res

    //==========================================================
    // serial port next state
    always_comb begin
        nxt_phase   = phase_ff;
        nxt_idle    = idle_ff;
        nxt_bcnt    = bcnt_ff;
        nxt_sh      = sh_ff;
        nxt_out     = out_ff;
        nxt_addr    = addr_ff;
        nxt_sdo     = sdo_ff;
        nxt_rdtouch = rdtouch_ff;
        if (cs_s) begin
            nxt_phase = PH_IDLE;
            nxt_bcnt  = 3'h0;
        end else if (cs_d_ff) begin
            nxt_phase   = PH_ADDR;
            nxt_idle    = sclk_s;
            nxt_bcnt    = 3'h0;
            nxt_rdtouch = 1'b0;
        end else begin
            if (shift_e && phase_ff == PH_DATA) begin
                nxt_sdo = out_ff[7];
                nxt_out = {out_ff[6:0], 1'b0};
            end
            if (strobe) begin
                nxt_sh   = byte_in;
                nxt_bcnt = 3'(bcnt_ff + 3'h1);
            end
            if (byte_done && phase_ff == PH_ADDR) begin
                nxt_addr  = byte_in;
                nxt_phase = PH_DATA;
                nxt_out   = reg_rd(byte_in[6:0]);
            end else if (byte_done) begin
                // address wraps within its half of the map
                nxt_addr = {addr_ff[7], 7'(idx + 7'h1)};
                nxt_out  = reg_rd(7'(idx + 7'h1));
                if (!addr_ff[ADR_WR_BIT] && is_res(idx)) begin
                    nxt_rdtouch = 1'b1;
                end
            end
        end
    end

    //==========================================================
    // register file next state
    always_comb begin
        nxt_cfg    = cfg_ff;
        nxt_hth    = hth_ff;
        nxt_lth    = lth_ff;
        nxt_res    = res_ff;
        nxt_pend_n = pend_n_ff;
        nxt_flt    = flt_ff;
        if (wr_en) begin
            case (idx)
                // clear and detect bits act once and read back zero
                ADR_CFG:    nxt_cfg = byte_in & ~CFG_SELF_MASK;
                ADR_HTH_HI: nxt_hth[15:8] = byte_in;
                ADR_HTH_LO: nxt_hth[7:0] = byte_in;
                ADR_LTH_HI: nxt_lth[15:8] = byte_in;
                ADR_LTH_LO: nxt_lth[7:0] = byte_in;
                default:    nxt_cfg = cfg_ff;
            endcase
        end
        // [R14] clear all fault bits
        if (clr_p) begin
            nxt_flt = FLT_RST;
        end
        // [R13] bits only ever set here; set beats clear
        if (trip.over) begin
            nxt_flt[FLT_OVER_BIT] = 1'b1;
        end
        if (trip.under) begin
            nxt_flt[FLT_UNDER_BIT] = 1'b1;
        end
        // [R12] on-demand reference check
        if (det_p && refhi_s) begin
            nxt_flt[FLT_REF_BIT] = 1'b1;
        end
        // [R2] release after a result read ends
        if (cs_rise && rdtouch_ff) begin
            nxt_pend_n = 1'b1;
        end
        // [R1] [R3] new result wins, pin low
        if (tconv.done) begin
            nxt_res    = tconv.code;
            nxt_pend_n = 1'b0;
        end
    end

    //==========================================================
    // registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            phase_ff   <= PH_IDLE;
            idle_ff    <= 1'b0;
            sclk_d_ff  <= 1'b0;
            cs_d_ff    <= 1'b1;
            bcnt_ff    <= 3'h0;
            sh_ff      <= 8'h00;
            out_ff     <= 8'h00;
            addr_ff    <= 8'h00;
            sdo_ff     <= 1'b0;
            rdtouch_ff <= 1'b0;
            cfg_ff     <= CFG_RST;
            // [R16] power-on thresholds
            hth_ff     <= HTH_RST;
            lth_ff     <= LTH_RST;
            flt_ff     <= FLT_RST;
            res_ff     <= RES_RST;
            pend_n_ff  <= 1'b1;
        end else begin
            phase_ff   <= nxt_phase;
            idle_ff    <= nxt_idle;
            sclk_d_ff  <= sclk_s;
            cs_d_ff    <= cs_s;
            bcnt_ff    <= nxt_bcnt;
            sh_ff      <= nxt_sh;
            out_ff     <= nxt_out;
            addr_ff    <= nxt_addr;
            sdo_ff     <= nxt_sdo;
            rdtouch_ff <= nxt_rdtouch;
            cfg_ff     <= nxt_cfg;
            hth_ff     <= nxt_hth;
            lth_ff     <= nxt_lth;
            flt_ff     <= nxt_flt;
            res_ff     <= nxt_res;
            pend_n_ff  <= nxt_pend_n;
        end
    end

    //==========================================================
    // result conditioning and trip compare
    rtdf_trip u_trip (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .conv_raw   (conv_in),
        .elem_open  (open_s),
        .elem_short (short_s),
        .high_thr   (hth_ff),
        .low_thr    (lth_ff),
        .conv_q     (tconv),
        .trip_q     (trip)
    );

    assign result_pending_n = pend_n_ff;
    assign sdo_o            = sdo_ff;
    // sdo stays off until a whole read byte is ready to go out
    assign sdo_oe           = !cs_s && phase_ff == PH_DATA
                              && !addr_ff[ADR_WR_BIT];

    //==========================================================
    // checks
    logic thr_wr_ff;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            thr_wr_ff <= 1'b0;
        end else if (wr_en && idx != ADR_CFG) begin
            thr_wr_ff <= 1'b1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_read_end;
        cs_rise && rdtouch_ff && !tconv.done;
    endsequence

    sequence s_clear_only;
        clr_p && !trip.over && !trip.under && !det_p;
    endsequence

    a_pend_on_result: assert property ( // [R1]
        tconv.done |=> !result_pending_n ##1 !result_pending_n
                       || $past(cs_rise))
        else $error("pending not low after result");
    a_pend_released: assert property ( // [R2]
        s_read_end |=> result_pending_n)
        else $error("pending not released after read");
    a_pend_overwrite: assert property ( // [R3]
        !result_pending_n && tconv.done
        |=> !result_pending_n && res_ff == $past(tconv.code))
        else $error("unread result not overwritten");
    a_res_bytes: assert property ( // [R4]
        tconv.done |=> {reg_rd(ADR_RES_HI), reg_rd(ADR_RES_LO)} ==
                       {$past(tconv.code), |flt_ff})
        else $error("result bytes wrong");
    a_over_latch: assert property ( // [R9]
        trip.over |=> flt_ff[FLT_OVER_BIT] [*2] or
                      (flt_ff[FLT_OVER_BIT] ##1 $past(clr_p)))
        else $error("over range flag not set");
    a_flt_hold: assert property ( // [R13]
        flt_ff[FLT_UNDER_BIT] && !clr_p |=> flt_ff[FLT_UNDER_BIT])
        else $error("fault bit lost without clear");
    a_flt_clear: assert property ( // [R14]
        s_clear_only |=> flt_ff == FLT_RST)
        else $error("fault clear incomplete");
    a_ref_detect: assert property ( // [R12]
        det_p && refhi_s |=> flt_ff[FLT_REF_BIT])
        else $error("reference check not flagged");
    a_thr_por: assert property ( // [R16]
        !thr_wr_ff |-> hth_ff == HTH_RST && lth_ff == LTH_RST)
        else $error("threshold reset value wrong");
endmodule : rtdf_core
`default_nettype wire

// ==== sim/rtdf_host.sv ====
/*
 * Host-side model of the serial register port master, CPOL set by cpol (0 at start), CPHA=1.
 * Assumes tb_top runs mclk and resolves the data-out wire it reads back.
 */
`timescale 1ns/1ps
`default_nettype none
module rtdf_host #(
    parameter int MS_CYC = 200
) (
    input  wire logic mclk,
    output var  logic cs_n,
    output var  logic sclk,
    output var  logic sdi,
    input  wire logic sdo
);
    // sclk half period in mclk cycles, above the four the port needs
    localparam int HALF = 5;

    // idle clock level; set by the bench between frames only
    logic cpol;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi  = 1'b0;
        cpol = 1'b0;
    end

    //==========================================================
    // byte shifter: data set on the leaving edge, sampled on return
    task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            @(posedge mclk);
            sclk <= ~cpol;
            sdi  <= tx[i];
            repeat (HALF) @(posedge mclk);
            rx[i] = sdo;
            sclk <= cpol;
            repeat (HALF - 1) @(posedge mclk);
        end
    endtask : shift

    //==========================================================
    // one framed transfer: address byte then n data bytes
    task automatic xfer(input logic [7:0] adr, input int n,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [7:0] b;
        rd = '0;
        // clock settles at its idle level before select is seen
        @(posedge mclk);
        sclk <= cpol;
        @(posedge mclk);
        cs_n <= 1'b0;
        repeat (4) @(posedge mclk);
        shift(adr, b);
        for (int k = 0; k < n; k++) begin
            shift(k == 0 ? wd[15:8] : wd[7:0], b);
            rd = {rd[7:0], b};
        end
        repeat (4) @(posedge mclk);
        cs_n <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask : xfer

    function automatic logic [31:0] ohms(input logic [14:0] c,
                                         input logic [15:0] rref);
        return ({17'h0, c} * {16'h0, rref}) >> 15;
    endfunction : ohms

    // settle before restart; one ms shortened to MS_CYC cycles
    task automatic settle(input int tau);
        repeat (5 * tau + MS_CYC) @(posedge mclk);
    endtask : settle
endmodule : rtdf_host
`default_nettype wire

// ==== sim/tb_top.sv ====
/*
 * Self-checking bench for rtdf_core with a host model on the serial port.
 * Assumes the conversion engine strobe is driven here on mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top import rtdf_pkg::*; ();
    logic        mclk;
    logic        reset_n;
    logic        cs_n;
    logic        sclk;
    logic        sdi;
    logic        sdo_o;
    logic        sdo_oe;
    logic        sdo;
    logic        sdo_last;
    logic        result_pending_n;
    rtdf_conv_t  conv_in;
    logic        element_open;
    logic        element_short;
    logic        ref_neg_high;
    logic [15:0] r;
    int          fails;
    int          n_compared;

    rtdf_core dut (
        .mclk(mclk), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk),
        .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .result_pending_n(result_pending_n), .conv_in(conv_in),
        .element_open(element_open), .element_short(element_short),
        .reference_input_neg_high(ref_neg_high)
    );
    rtdf_host host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
                    .sdo(sdo));

    // released line shows the inverse so stale data never passes
    always @(posedge mclk) if (sdo_oe) sdo_last <= sdo_o;
    assign sdo = sdo_oe ? sdo_o : ~sdo_last;

    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;

    //==========================================================
    // helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic conv(input logic [14:0] c);
        @(posedge mclk);
        conv_in <= '{done: 1'b1, code: c};
        @(posedge mclk);
        conv_in.done <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : conv

    task automatic rd_flt(input logic [7:0] exp);
        host.xfer(8'h07, 1, 16'h0, r);
        check(r, {8'h0, exp});
    endtask : rd_flt

    task automatic clr();
        host.xfer(8'h80, 1, 16'h0200, r);
    endtask : clr

    //==========================================================
    // scenarios
    task automatic t_reset();
        check({15'h0, result_pending_n}, 16'h0001);
        host.xfer(8'h03, 2, 16'h0, r);
        check(r, HTH_RST);
        host.xfer(8'h05, 2, 16'h0, r);
        check(r, LTH_RST);
        host.xfer(8'h7f, 1, 16'h0, r);
        check(r, {8'h0, INVALID_RD});
    endtask : t_reset

    task automatic t_result();
        conv(15'h2000);
        check({15'h0, result_pending_n}, 16'h0000);
        host.xfer(8'h81, 1, 16'h5500, r);
        check({15'h0, result_pending_n}, 16'h0000);
        host.xfer(8'h01, 2, 16'h0, r);
        check(r, {15'h2000, 1'b0});
        check({15'h0, result_pending_n}, 16'h0001);
        // code 2000h on a 400 ohm reference is 100 ohm
        check(16'(host.ohms(r[15:1], 16'h0190)), 16'h0064);
    endtask : t_result

    task automatic t_overwrite();
        @(posedge mclk);
        conv_in <= '{done: 1'b1, code: 15'h1111};
        @(posedge mclk);
        conv_in <= '{done: 1'b1, code: 15'h2222};
        @(posedge mclk);
        conv_in.done <= 1'b0;
        repeat (3) @(posedge mclk);
        check({15'h0, result_pending_n}, 16'h0000);
        host.xfer(8'h01, 2, 16'h0, r);
        check(r, {15'h2222, 1'b0});
    endtask : t_overwrite

    task automatic t_trip();
        host.xfer(8'h85, 2, {15'h0100, 1'b0}, r);
        host.xfer(8'h83, 2, {15'h6000, 1'b0}, r);
        conv(15'h6000);
        rd_flt(8'h80);
        host.xfer(8'h01, 2, 16'h0, r);
        check(r, {15'h6000, 1'b1});
        conv(15'h3000);
        rd_flt(8'h80);
        conv(15'h0100);
        rd_flt(8'hc0);
        clr();
        rd_flt(8'h00);
        host.xfer(8'h00, 1, 16'h0, r);
        check(r, 16'h0000);
        conv(15'h0101);
        rd_flt(8'h00);
        conv(15'h5fff);
        rd_flt(8'h00);
    endtask : t_trip

    task automatic t_element();
        element_open <= 1'b1;
        // the level needs two flops before it reaches the trip stage
        repeat (3) @(posedge mclk);
        conv(15'h1234);
        host.xfer(8'h01, 2, 16'h0, r);
        check(r, {CODE_FULL, 1'b1});
        rd_flt(8'h80);
        element_open  <= 1'b0;
        element_short <= 1'b1;
        clr();
        conv(15'h1234);
        host.xfer(8'h01, 2, 16'h0, r);
        check(r, {CODE_ZERO, 1'b1});
        rd_flt(8'h40);
        element_short <= 1'b0;
        clr();
    endtask : t_element

    task automatic t_ref();
        host.xfer(8'h80, 1, 16'h0400, r);
        host.xfer(8'h07, 1, 16'h0, r);
        check(r, 16'h0000);
        ref_neg_high <= 1'b1;
        repeat (4) @(posedge mclk);
        host.xfer(8'h80, 1, 16'h0400, r);
        ref_neg_high <= 1'b0;
        host.xfer(8'h07, 1, 16'h0, r);
        check(r, 16'h0020);
        clr();
        host.settle(4);
        rd_flt(8'h00);
    endtask : t_ref

    // idle-high serial clock, caught by the port at select
    task automatic t_cpol();
        host.cpol = 1'b1;
        host.xfer(8'h83, 2, {15'h4000, 1'b0}, r);
        host.xfer(8'h03, 2, 16'h0, r);
        check(r, {15'h4000, 1'b0});
        conv(15'h4000);
        rd_flt(8'h80);
        clr();
        rd_flt(8'h00);
        host.cpol = 1'b0;
    endtask : t_cpol

    //==========================================================
    // run control
    task automatic end_sim();
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    initial begin
        fails         = 0;
        n_compared    = 0;
        reset_n       = 1'b0;
        conv_in       = '0;
        element_open  = 1'b0;
        element_short = 1'b0;
        ref_neg_high  = 1'b0;
        sdo_last      = 1'b0;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (4) @(posedge mclk);
        t_reset();
        t_result();
        t_overwrite();
        t_trip();
        t_element();
        t_ref();
        t_cpol();
        end_sim();
    end

    // tests need about 7200 cycles; allow well beyond that
    initial begin
        repeat (60000) @(posedge mclk);
        fails++;
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
